/* src/root_hub_port_status_control.sv */
// Root hub downstream port status and control registers
`timescale 1ns/100ps
module root_hub_port_status_control #(
    parameter int PORT_COUNT = root_hub_port_pkg::PORT_MAX,
    parameter int RESET_CYCLES = root_hub_port_pkg::RESET_CYCLES,
    parameter int RESUME_PULSE_CYCLES = root_hub_port_pkg::RESUME_PULSE_CYCLES,
    parameter int RESYNC_CYCLES = root_hub_port_pkg::RESYNC_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_clock_en,
    input wire root_hub_port_pkg::cmd_type i_cmd,
    input wire logic [root_hub_port_pkg::PORT_MAX-1:0] i_transaction_busy,
    input wire logic [root_hub_port_pkg::PORT_MAX-1:0] i_connect_pin,
    input wire logic [root_hub_port_pkg::PORT_MAX-1:0] i_low_speed_pin,
    input wire logic [root_hub_port_pkg::PORT_MAX-1:0] i_overcurrent_pin,
    input wire logic [root_hub_port_pkg::PORT_MAX-1:0] i_non_removable_pin,
    output logic [31:0] o_rdata,
    output logic o_rvalid,
    output logic [root_hub_port_pkg::PORT_MAX-1:0] o_port_power,
    output logic [root_hub_port_pkg::PORT_MAX-1:0] o_reset_drive,
    output logic [root_hub_port_pkg::PORT_MAX-1:0] o_resume_drive
);
    localparam int CW = root_hub_port_pkg::COUNT_WIDTH;

    // Timers are CW bits wide, so longer counts cannot be served
    if (PORT_COUNT < 1 || PORT_COUNT > root_hub_port_pkg::PORT_MAX) begin : g_bad_port_count
        $error("PORT_COUNT out of range");
    end
    if (RESET_CYCLES < 1 || RESET_CYCLES >= (1 << CW)) begin : g_bad_reset_cycles
        $error("RESET_CYCLES out of range");
    end
    if (RESUME_PULSE_CYCLES < 1 || RESUME_PULSE_CYCLES >= (1 << CW)) begin : g_bad_pulse_cycles
        $error("RESUME_PULSE_CYCLES out of range");
    end
    if (RESYNC_CYCLES < 1 || RESYNC_CYCLES >= (1 << CW)) begin : g_bad_resync_cycles
        $error("RESYNC_CYCLES out of range");
    end
    if (root_hub_port_pkg::LS_EOP_CYCLES < 1 || root_hub_port_pkg::LS_EOP_CYCLES >= (1 << CW)) begin : g_bad_eop_cycles
        $error("LS_EOP_CYCLES out of range");
    end

    root_hub_port_pkg::state_type state;
    root_hub_port_pkg::state_type next_state;

    function automatic logic [31:0] pack_port(input root_hub_port_pkg::port_state_type p);
        logic [31:0] v;
        v = root_hub_port_pkg::RESET_VALUE;
        v[root_hub_port_pkg::BIT_CONNECT] = p.current_connect;
        v[root_hub_port_pkg::BIT_ENABLE] = p.port_enabled;
        v[root_hub_port_pkg::BIT_SUSPEND] = p.port_suspended;
        v[root_hub_port_pkg::BIT_OVERCURRENT] = p.port_overcurrent;
        v[root_hub_port_pkg::BIT_RESET] = p.port_in_reset;
        v[root_hub_port_pkg::BIT_POWER] = p.port_power_on;
        v[root_hub_port_pkg::BIT_LOW_SPEED] = p.low_speed_attached;
        v[root_hub_port_pkg::CHANGE_BASE +: 5] = p.changes;
        return v;
    endfunction

    // Each port answers its own read code; its write code adds the write flag
    function automatic logic [7:0] read_code(input int index);
        logic [7:0] code;
        code = root_hub_port_pkg::CODE_PORT_ONE;
        if (index == 1) begin
            code = root_hub_port_pkg::CODE_PORT_TWO;
        end
        return code;
    endfunction

    always_comb begin
        root_hub_port_pkg::port_state_type p;
        root_hub_port_pkg::port_state_type old;
        logic [7:0] port_code;
        logic hit_write;
        logic hit_read;
        logic [4:0] clr;
        logic [4:0] set;
        logic [9:0] cmd;
        logic live;

        p = '0;
        old = '0;
        port_code = 8'h00;
        hit_write = 1'b0;
        hit_read = 1'b0;
        clr = 5'h00;
        set = 5'h00;
        cmd = 10'h000;
        live = 1'b0;
        next_state = state;
        next_state.rvalid = 1'b0;
        // Every read in an enabled cycle answers, unmapped codes with zero, so software never waits
        if (i_cmd.valid && !i_cmd.code[7]) begin
            next_state.rvalid = 1'b1;
            next_state.rdata = 32'h0000_0000;
        end

        for (int i = 0; i < PORT_COUNT; i++) begin
            old = state.port[i];
            p = old;
            port_code = read_code(i);
            hit_write = i_cmd.valid && i_cmd.code == (port_code | root_hub_port_pkg::CODE_WRITE_FLAG);
            hit_read = i_cmd.valid && i_cmd.code == port_code;
            if (hit_read) begin
                next_state.rdata = pack_port(old);
            end

            // Pins cross in two flops before use
            p.conn_meta = i_connect_pin[i];
            p.conn_sync = old.conn_meta;
            p.ls_meta = i_low_speed_pin[i];
            p.ls_sync = old.ls_meta;
            p.oc_meta = i_overcurrent_pin[i];
            p.oc_sync = old.oc_meta;
            p.nr_meta = i_non_removable_pin[i];
            p.nr_sync = old.nr_meta;
            clr = 5'h00;
            set = 5'h00;
            cmd = 10'h000;
            if (hit_write) begin
                // Reserved write bits are simply ignored
                clr = i_cmd.wdata[root_hub_port_pkg::CHANGE_BASE +: 5];
                if (i_transaction_busy[i] || old.pend_valid) begin
                    // Deferred writes merge so none is lost behind a busy port
                    p.pend_valid = 1'b1;
                    p.pend_cmd = old.pend_cmd | i_cmd.wdata[9:0];
                end else begin
                    cmd = i_cmd.wdata[9:0];
                end
            end else if (old.pend_valid && !i_transaction_busy[i]) begin
                cmd = old.pend_cmd;
                p.pend_valid = 1'b0;
                p.pend_cmd = 10'h000;
            end

            // Port reset timer
            if (old.port_in_reset) begin
                if (old.count == CW'(1)) begin
                    p.port_in_reset = 1'b0;
                    p.port_enabled = 1'b1;
                    set[root_hub_port_pkg::CHG_RESET] = 1'b1;
                end else begin
                    p.count = old.count - CW'(1);
                end
            end

            // Resume sequence
            unique case (old.phase)
                root_hub_port_pkg::RESUME_IDLE: begin
                end
                root_hub_port_pkg::RESUME_PULSE: begin
                    if (old.count == CW'(1)) begin
                        p.phase = root_hub_port_pkg::RESUME_EOP;
                        p.count = CW'(root_hub_port_pkg::LS_EOP_CYCLES);
                    end else begin
                        p.count = old.count - CW'(1);
                    end
                end
                root_hub_port_pkg::RESUME_EOP: begin
                    if (old.count == CW'(1)) begin
                        p.phase = root_hub_port_pkg::RESUME_RESYNC;
                        p.count = CW'(RESYNC_CYCLES);
                    end else begin
                        p.count = old.count - CW'(1);
                    end
                end
                root_hub_port_pkg::RESUME_RESYNC: begin
                    if (old.count == CW'(1)) begin
                        p.phase = root_hub_port_pkg::RESUME_IDLE;
                        p.port_suspended = 1'b0;
                        set[root_hub_port_pkg::CHG_RESUME] = 1'b1;
                    end else begin
                        p.count = old.count - CW'(1);
                    end
                end
            endcase

            // Software commands; enable writes never raise enable change
            if (cmd[root_hub_port_pkg::CMD_CLR_ENABLE]) begin
                p.port_enabled = 1'b0;
            end
            if (cmd[root_hub_port_pkg::CMD_SET_ENABLE]) begin
                if (old.current_connect) begin
                    p.port_enabled = 1'b1;
                end else begin
                    set[root_hub_port_pkg::CHG_CONNECT] = 1'b1;
                end
            end
            if (cmd[root_hub_port_pkg::CMD_SET_SUSPEND]) begin
                if (!old.current_connect) begin
                    set[root_hub_port_pkg::CHG_CONNECT] = 1'b1;
                end else if (old.port_enabled) begin
                    p.port_suspended = 1'b1;
                end
            end
            if (cmd[root_hub_port_pkg::CMD_CLR_SUSPEND] && old.port_suspended &&
                old.phase == root_hub_port_pkg::RESUME_IDLE && !old.port_in_reset) begin
                p.phase = root_hub_port_pkg::RESUME_PULSE;
                p.count = CW'(RESUME_PULSE_CYCLES);
            end
            if (cmd[root_hub_port_pkg::CMD_SET_RESET]) begin
                if (!old.current_connect) begin
                    set[root_hub_port_pkg::CHG_CONNECT] = 1'b1;
                end else if (!old.port_in_reset) begin
                    // Reset overrides a resume in flight
                    p.port_in_reset = 1'b1;
                    p.port_suspended = 1'b0;
                    p.phase = root_hub_port_pkg::RESUME_IDLE;
                    p.count = CW'(RESET_CYCLES);
                end
            end
            if (cmd[root_hub_port_pkg::CMD_SET_POWER]) begin
                p.port_power_on = 1'b1;
            end
            if (cmd[root_hub_port_pkg::CMD_CLR_POWER]) begin
                p.port_power_on = 1'b0;
            end

            // Hardware events
            p.port_overcurrent = old.oc_sync;
            if (old.oc_sync != old.port_overcurrent) begin
                set[root_hub_port_pkg::CHG_OVERCURRENT] = 1'b1;
            end
            if (old.oc_sync) begin
                p.port_power_on = 1'b0;
            end
            // An unpowered port never reports a device, whatever its pin says
            live = p.port_power_on && old.conn_sync;
            p.current_connect = live;
            // Fixed devices announce once per root hub reset
            if (old.nr_sync) begin
                if (live && !old.announced) begin
                    p.announced = 1'b1;
                    set[root_hub_port_pkg::CHG_CONNECT] = 1'b1;
                end
            end else if (live != old.current_connect) begin
                set[root_hub_port_pkg::CHG_CONNECT] = 1'b1;
            end
            if (!live) begin
                // Power loss or disconnect drops enable, suspend, reset and resume; change flags stay
                if (old.port_enabled) begin
                    set[root_hub_port_pkg::CHG_ENABLE] = 1'b1;
                end
                p.port_enabled = 1'b0;
                p.port_suspended = 1'b0;
                p.port_in_reset = 1'b0;
                p.phase = root_hub_port_pkg::RESUME_IDLE;
                set[root_hub_port_pkg::CHG_RESET] = 1'b0;
                set[root_hub_port_pkg::CHG_RESUME] = 1'b0;
            end
            p.low_speed_attached = live && old.ls_sync;
            // Registered so the resume output comes straight from a flop
            p.resuming = p.phase != root_hub_port_pkg::RESUME_IDLE;

            // A hardware set wins over a same-cycle software clear
            p.changes = (old.changes & ~clr) | set;
            if (set[root_hub_port_pkg::CHG_RESET]) begin
                p.changes[root_hub_port_pkg::CHG_RESUME] = 1'b0;
            end

            if (i_clock_en) begin
                next_state.port[i] = p;
            end
        end

        // Frozen cycles keep every flop, the read answer too
        if (!i_clock_en) begin
            next_state = state;
        end
    end

    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    always_comb begin
        o_rdata = state.rdata;
        o_rvalid = state.rvalid;
        for (int i = 0; i < root_hub_port_pkg::PORT_MAX; i++) begin
            o_port_power[i] = state.port[i].port_power_on;
            o_reset_drive[i] = state.port[i].port_in_reset;
            o_resume_drive[i] = state.port[i].resuming;
        end
    end
endmodule

/* src/root_hub_port_pkg.sv */
// Constants and types for the root hub downstream port status block
package root_hub_port_pkg;
    localparam int PORT_MAX = 2;
    localparam logic [7:0] CODE_PORT_ONE = 8'h15;
    localparam logic [7:0] CODE_PORT_TWO = 8'h16;
    localparam logic [7:0] CODE_WRITE_FLAG = 8'h80;
    // Status bits on read, command bits on write
    localparam int BIT_CONNECT = 0;
    localparam int BIT_ENABLE = 1;
    localparam int BIT_SUSPEND = 2;
    localparam int BIT_OVERCURRENT = 3;
    localparam int BIT_RESET = 4;
    localparam int BIT_POWER = 8;
    localparam int BIT_LOW_SPEED = 9;
    localparam int CMD_CLR_ENABLE = 0;
    localparam int CMD_SET_ENABLE = 1;
    localparam int CMD_SET_SUSPEND = 2;
    localparam int CMD_CLR_SUSPEND = 3;
    localparam int CMD_SET_RESET = 4;
    localparam int CMD_SET_POWER = 8;
    localparam int CMD_CLR_POWER = 9;
    // Change flags, offset from bit 16
    localparam int CHANGE_BASE = 16;
    localparam int CHG_CONNECT = 0;
    localparam int CHG_ENABLE = 1;
    localparam int CHG_RESUME = 2;
    localparam int CHG_OVERCURRENT = 3;
    localparam int CHG_RESET = 4;
    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
    // Timing
    localparam int CLOCK_NS = 10;
    localparam int RESET_TIME_MS = 10;
    localparam int RESUME_PULSE_MS = 20;
    localparam int RESYNC_MS = 3;
    localparam int LS_EOP_NS = 1333;
    localparam int RESET_CYCLES = RESET_TIME_MS * 1000000 / CLOCK_NS;
    localparam int RESUME_PULSE_CYCLES = RESUME_PULSE_MS * 1000000 / CLOCK_NS;
    localparam int RESYNC_CYCLES = RESYNC_MS * 1000000 / CLOCK_NS;
    localparam int LS_EOP_CYCLES = (LS_EOP_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam int COUNT_WIDTH = 24;

    typedef enum logic [1:0] {
        RESUME_IDLE = 2'b00,
        RESUME_PULSE = 2'b01,
        RESUME_EOP = 2'b10,
        RESUME_RESYNC = 2'b11
    } resume_phase_type;

    typedef struct packed {
        logic valid;
        logic [7:0] code;
        logic [31:0] wdata;
    } cmd_type;

    typedef struct packed {
        logic conn_meta;
        logic conn_sync;
        logic ls_meta;
        logic ls_sync;
        logic oc_meta;
        logic oc_sync;
        logic nr_meta;
        logic nr_sync;
        logic current_connect;
        logic port_enabled;
        logic port_suspended;
        logic port_overcurrent;
        logic port_in_reset;
        logic port_power_on;
        logic low_speed_attached;
        logic announced;
        logic [4:0] changes;
        resume_phase_type phase;
        logic resuming;
        logic [COUNT_WIDTH-1:0] count;
        logic pend_valid;
        logic [9:0] pend_cmd;
    } port_state_type;

    typedef struct packed {
        port_state_type [PORT_MAX-1:0] port;
        logic [31:0] rdata;
        logic rvalid;
    } state_type;
endpackage

/* verification/root_hub_port_chk.sv */
// Port-level assertions for the root hub port status block
`timescale 1ns/100ps
module root_hub_port_chk #(
    parameter int RESET_CYCLES = root_hub_port_pkg::RESET_CYCLES
) (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_clock_en,
    input wire root_hub_port_pkg::cmd_type i_cmd,
    input wire logic [root_hub_port_pkg::PORT_MAX-1:0] i_transaction_busy,
    input wire logic [root_hub_port_pkg::PORT_MAX-1:0] i_connect_pin,
    input wire logic [root_hub_port_pkg::PORT_MAX-1:0] i_low_speed_pin,
    input wire logic [root_hub_port_pkg::PORT_MAX-1:0] i_overcurrent_pin,
    input wire logic [root_hub_port_pkg::PORT_MAX-1:0] i_non_removable_pin,
    input wire logic [31:0] o_rdata,
    input wire logic o_rvalid,
    input wire logic [root_hub_port_pkg::PORT_MAX-1:0] o_port_power,
    input wire logic [root_hub_port_pkg::PORT_MAX-1:0] o_reset_drive,
    input wire logic [root_hub_port_pkg::PORT_MAX-1:0] o_resume_drive
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rstn);
    // Reset signalling may outlast any plain delay, so its length is counted
    logic [31:0] reset_run;
    always_ff @(posedge i_clock or negedge i_rstn) begin
        if (!i_rstn) begin
            reset_run <= 32'h0000_0000;
        end else if (i_clock_en) begin
            reset_run <= o_reset_drive[0] ? reset_run + 32'h0000_0001 : 32'h0000_0000;
        end
    end
    sequence read_taken;
        i_clock_en && i_cmd.valid && !i_cmd.code[7];
    endsequence
    sequence resume_begin;
        $rose(o_resume_drive[0]);
    endsequence
    a_read_answered: assert property (read_taken |=> o_rvalid)
        else $error("read got no answer");
    a_unmapped_zero: assert property (read_taken ##0 (i_cmd.code != root_hub_port_pkg::CODE_PORT_ONE
        && i_cmd.code != root_hub_port_pkg::CODE_PORT_TWO) |=> o_rdata == 32'h0) else $error("unmapped read not zero");
    a_reserved_zero: assert property (o_rvalid |-> o_rdata[31:21] == 11'h0 && o_rdata[15:10] == 6'h0)
        else $error("reserved bits set");
    a_speed_needs_connect: assert property (o_rvalid && !o_rdata[0] |-> !o_rdata[9])
        else $error("speed shown while detached");
    a_reset_length: assert property ($fell(o_reset_drive[0]) |-> reset_run == 32'(RESET_CYCLES))
        else $error("port reset length wrong");
    a_overcurrent_power: assert property ($rose(i_overcurrent_pin[0]) |-> ##[1:4] !o_port_power[0])
        else $error("power kept on overcurrent");
    a_busy_defers: assert property ($rose(o_reset_drive[0]) |-> !$past(i_transaction_busy[0]))
        else $error("reset started during transaction");
    a_resume_holds: assert property (resume_begin |-> o_resume_drive[0] [*8])
        else $error("resume cut short");
endmodule
bind root_hub_port_status_control root_hub_port_chk #(.RESET_CYCLES(RESET_CYCLES)) chk_u (.i_clock(i_clock),
    .i_rstn(i_rstn), .i_clock_en(i_clock_en), .i_cmd(i_cmd), .i_transaction_busy(i_transaction_busy),
    .i_connect_pin(i_connect_pin), .i_low_speed_pin(i_low_speed_pin), .i_overcurrent_pin(i_overcurrent_pin),
    .i_non_removable_pin(i_non_removable_pin), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_port_power(o_port_power),
    .o_reset_drive(o_reset_drive), .o_resume_drive(o_resume_drive));

/* verification/usb_port_device_model.sv */
// Behavioural USB device on one downstream port's pins
`timescale 1ns/100ps
module usb_port_device_model (
    input wire logic i_clock,
    input wire logic i_attach,
    input wire logic i_low_speed,
    input wire logic i_fault,
    output logic o_connect = 1'b0,
    output logic o_low_speed = 1'b0,
    output logic o_overcurrent = 1'b0
);
    logic toggle = 1'b0;
    always @(negedge i_clock) begin
        toggle <= ~toggle;
        o_connect <= i_attach;
        // Speed line floats when unplugged, so it wanders
        o_low_speed <= i_attach ? i_low_speed : toggle;
        o_overcurrent <= i_fault;
    end
endmodule

/* verification/testbench.sv */
// Self-checking bench for the root hub port status block
`timescale 1ns/100ps
module testbench;
    localparam logic [7:0] ONE = root_hub_port_pkg::CODE_PORT_ONE;
    localparam logic [7:0] TWO = root_hub_port_pkg::CODE_PORT_TWO;
    localparam logic [7:0] W1 = ONE | root_hub_port_pkg::CODE_WRITE_FLAG;
    localparam logic [7:0] W2 = TWO | root_hub_port_pkg::CODE_WRITE_FLAG;
    // Short counts keep the run brief
    localparam int RST_N = 20;
    localparam int PULSE_N = 20;
    localparam int SYNC_N = 10;
    logic i_clock = 1'b0;
    logic i_rstn = 1'b0;
    root_hub_port_pkg::cmd_type i_cmd = '0;
    logic [1:0] busy = 2'b00;
    logic [1:0] attach = 2'b00;
    logic [1:0] low = 2'b00;
    logic [1:0] fault = 2'b00;
    wire [1:0] conn_w;
    wire [1:0] low_w;
    wire [1:0] oc_w;
    wire [31:0] rdata;
    wire rvalid;
    wire [1:0] pwr;
    wire [1:0] rst_drv;
    wire [1:0] res_drv;
    logic run = 1'b1;
    int mismatches = 0;
    int checked = 0;
    int seed = 53296;
    logic ls;
    logic [4:0] mask;
    always #5 i_clock = ~i_clock;
    for (genvar p = 0; p < 2; p++) begin : g_dev
        usb_port_device_model dev_u (.i_clock(i_clock), .i_attach(attach[p]), .i_low_speed(low[p]),
            .i_fault(fault[p]), .o_connect(conn_w[p]), .o_low_speed(low_w[p]), .o_overcurrent(oc_w[p]));
    end
    root_hub_port_status_control #(.RESET_CYCLES(RST_N), .RESUME_PULSE_CYCLES(PULSE_N), .RESYNC_CYCLES(SYNC_N)) dut_u (
        .i_clock(i_clock), .i_rstn(i_rstn), .i_clock_en(run), .i_cmd(i_cmd), .i_transaction_busy(busy),
        .i_connect_pin(conn_w), .i_low_speed_pin(low_w), .i_overcurrent_pin(oc_w), .i_non_removable_pin(2'b10),
        .o_rdata(rdata), .o_rvalid(rvalid), .o_port_power(pwr), .o_reset_drive(rst_drv), .o_resume_drive(res_drv));
    function automatic logic [31:0] word(input logic [4:0] chg, input logic [9:0] st);
        return {11'h000, chg, 6'h00, st};
    endfunction
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic check_level(input string name, input logic exp, input logic seen);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %b seen %b", name, exp, seen);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge i_clock);
    endtask
    // Valid drops a full cycle later, so calls never collide
    task automatic cmd(input logic [7:0] code, input logic [31:0] data);
        @(negedge i_clock);
        i_cmd <= '{valid: 1'b1, code: code, wdata: data};
        @(negedge i_clock);
        i_cmd <= '0;
    endtask
    task automatic rd(input logic [7:0] code, input logic [31:0] exp, input string name);
        cmd(code, 32'h0);
        check({name, " valid"}, 32'h1, {31'h0, rvalid});
        check(name, exp, rdata);
    endtask
    task automatic complete_run;
        if (mismatches == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Script needs under 700 cycles
    initial begin
        #20000;
        mismatches++;
        $display("[FAIL] watchdog expected done seen hang");
        complete_run();
    end
    initial begin
        wt(6);
        i_rstn <= 1'b1;
        rd(ONE, 32'h0, "one reset");
        rd(TWO, 32'h0, "two reset");
        rd(8'h17, 32'h0, "unmapped");
        for (int b = 1; b <= 4; b = b * 2) begin
            cmd(W1, 32'h1 << b);
            cmd(W1, 32'h0);
            rd(ONE, word(5'h01, 10'h000), "detached cmd");
            cmd(W1, 32'h0001_0000);
        end
        ls = 1'($random(seed));
        low[0] <= ls;
        cmd(W1, 32'h0000_0100);
        attach[0] <= 1'b1;
        wt(6);
        rd(ONE, word(5'h01, {ls, 9'h101}), "attach");
        check_level("power on", 1'b1, pwr[0]);
        cmd(W1, 32'h0001_0010);
        wt(2);
        check_level("reset drive", 1'b1, rst_drv[0]);
        wt(RST_N + 2);
        rd(ONE, word(5'h10, {ls, 9'h103}), "reset done");
        check_level("reset drive end", 1'b0, rst_drv[0]);
        busy[0] <= 1'b1;
        cmd(W1, 32'h0000_0004);
        wt(4);
        rd(ONE, word(5'h10, {ls, 9'h103}), "suspend held");
        busy[0] <= 1'b0;
        wt(2);
        rd(ONE, word(5'h10, {ls, 9'h107}), "suspended");
        cmd(W1, 32'h0010_0008);
        wt(5);
        check_level("resume drive", 1'b1, res_drv[0]);
        wt(PULSE_N + root_hub_port_pkg::LS_EOP_CYCLES + SYNC_N + 15);
        rd(ONE, word(5'h04, {ls, 9'h103}), "resume done");
        check_level("resume drive end", 1'b0, res_drv[0]);
        cmd(W1, 32'h0000_0010);
        wt(RST_N + 4);
        rd(ONE, word(5'h10, {ls, 9'h103}), "resume flag drop");
        cmd(W1, 32'h0010_0001);
        rd(ONE, word(5'h00, {ls, 9'h101}), "soft disable");
        cmd(W1, 32'h0000_0002);
        attach[0] <= 1'b0;
        wt(6);
        rd(ONE, word(5'h03, 10'h100), "unplug");
        fault[0] <= 1'b1;
        wt(6);
        rd(ONE, word(5'h0b, 10'h008), "overcurrent");
        check_level("power cut", 1'b0, pwr[0]);
        run <= 1'b0;
        cmd(W1, 32'h001f_0000);
        run <= 1'b1;
        rd(ONE, word(5'h0b, 10'h008), "frozen clear");
        mask = 5'($random(seed));
        cmd(W1, {11'h000, mask, 16'h0000});
        rd(ONE, word(5'h0b & ~mask, 10'h008), "random clear");
        cmd(W1, 32'h001f_0000);
        fault[0] <= 1'b0;
        wt(6);
        rd(ONE, word(5'h08, 10'h000), "overcurrent gone");
        cmd(W2, 32'h0000_0100);
        attach[1] <= 1'b1;
        wt(6);
        rd(TWO, word(5'h01, 10'h101), "fixed device");
        cmd(W2, 32'h0001_0000);
        attach[1] <= 1'b0;
        wt(6);
        attach[1] <= 1'b1;
        wt(6);
        rd(TWO, word(5'h00, 10'h101), "fixed replug");
        i_rstn <= 1'b0;
        wt(2);
        i_rstn <= 1'b1;
        rd(TWO, 32'h0, "two rearm");
        cmd(W2, 32'h0000_0100);
        wt(6);
        rd(TWO, word(5'h01, 10'h101), "fixed after reset");
        complete_run();
    end
endmodule
